// ---- tplc_defines.vh ----
// Constants for the test pattern and loop code unit
`ifndef TPLC_DEFINES_VH
`define TPLC_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define TPLC_ADDR_CH0 8'h00
`define TPLC_ADDR_CH1 8'h04
`define TPLC_ADDR_CH2 8'h08
`define TPLC_ADDR_CH3 8'h0C
`define TPLC_ADDR_GLOBAL 8'h10
`define TPLC_ADDR_STATUS 8'h14
`define TPLC_ADDR_MASK 8'h18
`define TPLC_ADDR_STATE 8'h1C

// ----------------------------------------------------------------------
// Channel control fields
// ----------------------------------------------------------------------
`define TPLC_CTL_W 6
`define TPLC_TPS_LSB 0
`define TPLC_TPS_MSB 2
`define TPLC_DSEL_LSB 3
`define TPLC_DSEL_MSB 4
`define TPLC_ALOOP_BIT 5
`define TPLC_GLB_AUTO_BIT 0

// ----------------------------------------------------------------------
// Test pattern codes and detect modes
// ----------------------------------------------------------------------
`define TPLC_TPS_QRSS 3'h4
`define TPLC_TPS_ONES 3'h5
`define TPLC_TPS_LUP 3'h6
`define TPLC_TPS_LDN 3'h7
`define TPLC_DET_OFF 2'h0
`define TPLC_DET_UP 2'h1
`define TPLC_DET_DOWN 2'h2
`define TPLC_DET_AUTO 2'h3

// ----------------------------------------------------------------------
// Loop code shape and timing
// ----------------------------------------------------------------------
`define TPLC_UP_LAST 3'h4
`define TPLC_DN_LAST 3'h2
`define TPLC_QUAL_SEC 5
`define TPLC_CLK_HZ 25000000
`define TPLC_LFSR_SEED 20'h00001

`endif

// ---- tplc_unit.v ----
// Four channel test pattern generator and network loop code detector
//
// Functional notes
// - Host select: 0xx none, 100 quasi-random, 101 ones, 110 up, 111 down.
// - Hardware mode: each channel's all-ones pin forces all ones independently.
// - All ones ignores transmit data, sends AMI ones paced by transmit clock.
// - Global auto all-ones sends ones on every channel reporting signal loss.
// - Loop-up pattern repeats 00001 toward the remote terminal.
// - Loop-down pattern repeats 001 toward the remote terminal.
// - Two-bit detect select: off, loop-up, loop-down, auto with loop-back.
// - Loop-up mode: flag set after 00001 over 5 s, held while code persists.
// - Loop-down mode: flag set after 001 received over 5 s.
// - Every rise or fall of the detected flag raises an enabled interrupt.
// - Auto mode needs select not 110; entry clears flag, watches loop-up.
// - Auto: up code over 5 s sets flag, starts loop-back, watches down.
// - Auto: loop-down over 5 s ends loop-back, clears flag, interrupts.
// - Leaving automatic mode removes loop-back that automatic mode started.
// - Loop-back requests are ignored while local analog loop-back is on.
`include "tplc_defines.vh"
`default_nettype none

module tplc_unit #(
	parameter CHANNELS = 4,
	parameter [31:0] QUAL_CYCLES = `TPLC_QUAL_SEC * `TPLC_CLK_HZ
) (
	// Clock and reset
	input wire clk_in,
	input wire reset_in,
	// Register port
	input wire [7:0] addr_in,
	input wire [31:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output wire [31:0] rdata_out,
	output wire irq_out,
	// Mode and global pins
	input wire host_mode_in,
	input wire auto_all_ones_on_loss_pin_in,
	// Per channel pins
	input wire [3:0] all_ones_request_pin_in,
	input wire [3:0] receive_signal_loss_in,
	input wire [3:0] transmit_clock_in,
	input wire [3:0] transmit_positive_data_in,
	input wire [3:0] transmit_negative_data_in,
	input wire [3:0] receive_clock_in,
	input wire [3:0] receive_data_in,
	// Per channel results
	output wire [3:0] tx_pos_out,
	output wire [3:0] tx_neg_out,
	output wire [3:0] remote_loop_out,
	output wire [3:0] loop_code_detected_flag_out
);

	// ------------------------------------------------------------------
	// Local names
	// ------------------------------------------------------------------
	localparam ST_WATCH_UP = 1'b0;
	localparam ST_LOOPED = 1'b1;

	// Exactly one bit set in a window of w bits
	function one_hot;
		input [4:0] v;
		input [2:0] w;
		integer k;
		reg [2:0] n;
		begin
			n = 3'h0;
			for (k = 0; k < 5; k = k + 1) begin
				if (k < w && v[k])
					n = n + 3'h1;
			end
			one_hot = (n == 3'h1);
		end
	endfunction

	// Received history matches the loop-up (5 bit) or loop-down (3 bit) code
	// A partial history after reset is zero filled and can already match once a one is in the window.
	function code_match;
		input down;
		input [5:0] h;
		begin
			if (down)
				code_match = one_hot({2'h0, h[2:0]}, 3'h3) && (h[3] == h[0]);
			else
				code_match = one_hot(h[4:0], 3'h5) && (h[5] == h[0]);
		end
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	reg [CHANNELS-1:0] aos_s1, aos_s2, los_s1, los_s2;
	reg [CHANNELS-1:0] txc_s1, txc_s2, txc_s3;
	reg [CHANNELS-1:0] txp_s1, txp_s2, txn_s1, txn_s2;
	reg [CHANNELS-1:0] rxc_s1, rxc_s2, rxc_s3, rxd_s1, rxd_s2;
	reg host_s1, host_s2, apin_s1, apin_s2;

	// Two stages on every pin; only the second stage feeds logic.
	// The clock pins get a third stage so that an edge can be seen
	// without ever reading the first, possibly metastable, stage.
	// Every pin lands with the same two-cycle delay, so a data pin
	// and the mode pins that qualify it change in the same cycle.
	always @(posedge clk_in) begin
		aos_s1 <= all_ones_request_pin_in;
		aos_s2 <= aos_s1;
		los_s1 <= receive_signal_loss_in;
		los_s2 <= los_s1;
		txc_s1 <= transmit_clock_in;
		txc_s2 <= txc_s1;
		txc_s3 <= txc_s2;
		txp_s1 <= transmit_positive_data_in;
		txp_s2 <= txp_s1;
		txn_s1 <= transmit_negative_data_in;
		txn_s2 <= txn_s1;
		rxc_s1 <= receive_clock_in;
		rxc_s2 <= rxc_s1;
		rxc_s3 <= rxc_s2;
		rxd_s1 <= receive_data_in;
		rxd_s2 <= rxd_s1;
		host_s1 <= host_mode_in;
		host_s2 <= host_s1;
		apin_s1 <= auto_all_ones_on_loss_pin_in;
		apin_s2 <= apin_s1;
	end

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	// Channel controls sit at the first four words, one per channel:
	// pattern select in the low three bits, detect select above it and
	// the local analog loop-back bit on top. Status clears on a written
	// one; a set in the same cycle wins so that no edge is ever lost.
	reg [`TPLC_CTL_W-1:0] ch_ctrl [0:CHANNELS-1];
	reg auto_aos_bit;
	reg [CHANNELS-1:0] int_status, int_mask;
	reg [31:0] rdata;
	reg irq;
	wire [CHANNELS-1:0] flag_event;
	wire [CHANNELS-1:0] flag_w, loop_w, txp_w, txn_w;
	wire clr_hit = wr_in && (addr_in == `TPLC_ADDR_STATUS);
	wire [CHANNELS-1:0] clr_bits = clr_hit ? wdata_in[CHANNELS-1:0] :
		{CHANNELS{1'b0}};
	wire [CHANNELS-1:0] next_status = (int_status & ~clr_bits) | flag_event;
	// Global all-ones: register bit in host mode, pin in hardware mode
	wire auto_aos = host_s2 ? auto_aos_bit : apin_s2;
	integer c;

	// Writes; a flag change in the clearing cycle keeps its status bit
	always @(posedge clk_in) begin
		if (reset_in) begin
			for (c = 0; c < CHANNELS; c = c + 1)
				ch_ctrl[c] <= {`TPLC_CTL_W{1'b0}};
			auto_aos_bit <= 1'b0;
			int_status <= {CHANNELS{1'b0}};
			int_mask <= {CHANNELS{1'b0}};
			irq <= 1'b0;
		end else begin
			if (wr_in) begin
				case (addr_in)
				`TPLC_ADDR_CH0: ch_ctrl[0] <= wdata_in[`TPLC_CTL_W-1:0];
				`TPLC_ADDR_CH1: ch_ctrl[1] <= wdata_in[`TPLC_CTL_W-1:0];
				`TPLC_ADDR_CH2: ch_ctrl[2] <= wdata_in[`TPLC_CTL_W-1:0];
				`TPLC_ADDR_CH3: ch_ctrl[3] <= wdata_in[`TPLC_CTL_W-1:0];
				`TPLC_ADDR_GLOBAL: auto_aos_bit <= wdata_in[`TPLC_GLB_AUTO_BIT];
				`TPLC_ADDR_MASK: int_mask <= wdata_in[CHANNELS-1:0];
				default: ;
				endcase
			end
			int_status <= next_status;
			irq <= |(next_status & int_mask);
		end
	end

	// Read data stands one cycle after the strobe, zero otherwise
	// Zero outside the slot lets several slaves share an OR-ed bus.
	always @(posedge clk_in) begin
		if (reset_in) begin
			rdata <= 32'h00000000;
		end else if (rd_in) begin
			case (addr_in)
			`TPLC_ADDR_CH0: rdata <= {26'h0000000, ch_ctrl[0]};
			`TPLC_ADDR_CH1: rdata <= {26'h0000000, ch_ctrl[1]};
			`TPLC_ADDR_CH2: rdata <= {26'h0000000, ch_ctrl[2]};
			`TPLC_ADDR_CH3: rdata <= {26'h0000000, ch_ctrl[3]};
			`TPLC_ADDR_GLOBAL: rdata <= {31'h00000000, auto_aos_bit};
			`TPLC_ADDR_STATUS: rdata <= {28'h0000000, int_status};
			`TPLC_ADDR_MASK: rdata <= {28'h0000000, int_mask};
			`TPLC_ADDR_STATE: rdata <= {20'h00000, los_s2, loop_w, flag_w};
			default: rdata <= 32'h00000000;
			endcase
		end else begin
			rdata <= 32'h00000000;
		end
	end

	// ------------------------------------------------------------------
	// Per channel pattern generator and loop code detector
	// ------------------------------------------------------------------
	genvar i;
	generate
	for (i = 0; i < CHANNELS; i = i + 1) begin : ch
		wire [2:0] tps = ch_ctrl[i][`TPLC_TPS_MSB:`TPLC_TPS_LSB];
		wire [1:0] dsel = ch_ctrl[i][`TPLC_DSEL_MSB:`TPLC_DSEL_LSB];
		wire aloop = ch_ctrl[i][`TPLC_ALOOP_BIT];
		wire tx_tick = txc_s2[i] & ~txc_s3[i];
		wire rx_tick = rxc_s2[i] & ~rxc_s3[i];
		// Automatic mode is void while the loop-up code is being sent
		wire auto_on = host_s2 && (dsel == `TPLC_DET_AUTO) &&
			(tps != `TPLC_TPS_LUP);
		wire man_up = host_s2 && (dsel == `TPLC_DET_UP);
		wire man_dn = host_s2 && (dsel == `TPLC_DET_DOWN);
		reg phase, auto_q, want_q, flag, flag_q, loop;
		reg [5:0] hist;
		reg [31:0] cnt;
		reg [2:0] pcnt;
		reg [19:0] lfsr;
		reg pol, txp, txn;
		wire want_dn = man_dn || (auto_on && phase == ST_LOOPED);
		wire bit_ok = code_match(want_dn, hist);
		wire qual = bit_ok && (want_dn == want_q) && (cnt == QUAL_CYCLES);
		wire ones_sel = host_s2 ? (tps == `TPLC_TPS_ONES) : aos_s2[i];
		wire all_ones = ones_sel || (auto_aos && los_s2[i]);
		reg pbit;

		// Received bit history, one shift per rising receive clock edge.
		// Six bits are kept: the last five hold one period of the up
		// code and the sixth must repeat the newest, so that a lone
		// stray one among idle zeros does not match on the bit that brings it in.
		always @(posedge clk_in) begin
			if (reset_in)
				hist <= 6'h00;
			else if (rx_tick)
				hist <= {hist[4:0], rxd_s2[i]};
		end

		// Qualification timer; a broken code or new target restarts it
		// The count saturates at the limit instead of wrapping, so a
		// code held for hours keeps its flag without a glitch.
		always @(posedge clk_in) begin
			if (reset_in) begin
				cnt <= 32'h00000000;
				want_q <= 1'b0;
			end else begin
				want_q <= want_dn;
				if (!bit_ok || want_dn != want_q || !(man_up || man_dn ||
					auto_on))
					cnt <= 32'h00000000;
				else if (cnt != QUAL_CYCLES)
					cnt <= cnt + 32'h00000001;
			end
		end

		// Detected flag and automatic loop-back sequencing
		// Automatic mode holds flag and loop-back after the up code goes
		// away; only a qualified down code or leaving the mode ends them.
		// The analog loop-back bit blocks setting the flag and the loop-back in every mode and drops a manual-mode flag; it never blocks an auto release.
		always @(posedge clk_in) begin
			if (reset_in) begin
				phase <= ST_WATCH_UP;
				auto_q <= 1'b0;
				flag <= 1'b0;
				loop <= 1'b0;
			end else begin
				auto_q <= auto_on;
				if (auto_on && !auto_q) begin
					flag <= 1'b0;
					loop <= 1'b0;
					phase <= ST_WATCH_UP;
				end else if (auto_on) begin
					case (phase)
					ST_WATCH_UP: begin
						if (qual && !aloop) begin
							flag <= 1'b1;
							loop <= 1'b1;
							phase <= ST_LOOPED;
						end
					end
					ST_LOOPED: begin
						if (qual) begin
							flag <= 1'b0;
							loop <= 1'b0;
							phase <= ST_WATCH_UP;
						end
					end
					default: phase <= ST_WATCH_UP;
					endcase
				end else begin
					// Manual modes flag only while the code keeps arriving
					flag <= (man_up || man_dn) && qual && !aloop;
					loop <= 1'b0;
					phase <= ST_WATCH_UP;
				end
			end
		end

		// Edge of the flag in either direction becomes an event
		always @(posedge clk_in) begin
			if (reset_in)
				flag_q <= 1'b0;
			else
				flag_q <= flag;
		end
		assign flag_event[i] = flag ^ flag_q;

		// Pattern bit for the current transmit slot
		// Quasi-random here is a plain shift register, not a line pattern.
		always @* begin
			case (tps)
			`TPLC_TPS_QRSS: pbit = lfsr[19];
			`TPLC_TPS_LUP: pbit = (pcnt == `TPLC_UP_LAST);
			`TPLC_TPS_LDN: pbit = (pcnt == `TPLC_DN_LAST);
			default: pbit = 1'b1;
			endcase
		end

		// Transmit stage, advanced once per rising transmit clock edge
		// Marks alternate polarity across pattern zeros; a stopped
		// transmit clock freezes the rails where they are.
		always @(posedge clk_in) begin
			if (reset_in) begin
				pcnt <= 3'h0;
				lfsr <= `TPLC_LFSR_SEED;
				pol <= 1'b0;
				txp <= 1'b0;
				txn <= 1'b0;
			end else if (tx_tick) begin
				if ((tps == `TPLC_TPS_LUP && pcnt == `TPLC_UP_LAST) ||
					(tps == `TPLC_TPS_LDN && pcnt == `TPLC_DN_LAST))
					pcnt <= 3'h0;
				else
					pcnt <= pcnt + 3'h1;
				lfsr <= {lfsr[18:0], lfsr[19] ^ lfsr[16]};
				if (all_ones || (host_s2 && tps[2])) begin
					// Input data is ignored; ones alternate polarity
					if (all_ones || pbit) begin
						txp <= ~pol;
						txn <= pol;
						pol <= ~pol;
					end else begin
						txp <= 1'b0;
						txn <= 1'b0;
					end
				end else begin
					txp <= txp_s2[i];
					txn <= txn_s2[i];
				end
			end
		end

		assign flag_w[i] = flag;
		assign loop_w[i] = loop;
		assign txp_w[i] = txp;
		assign txn_w[i] = txn;
	end
	endgenerate

	// ------------------------------------------------------------------
	// Outputs, each straight from a flip-flop
	// ------------------------------------------------------------------
	// Nothing here is combined again, so the pins never glitch when
	// several channel flops change in one cycle.
	assign rdata_out = rdata;
	assign irq_out = irq;
	assign tx_pos_out = txp_w;
	assign tx_neg_out = txn_w;
	assign remote_loop_out = loop_w;
	assign loop_code_detected_flag_out = flag_w;

endmodule // tplc_unit

`default_nettype wire

// ---- tplc_remote_term.sv ----
// Remote line terminal model that sends loop codes toward the unit
`default_nettype none
// ----------------------------------------------------------------------
// Remote terminal
// ----------------------------------------------------------------------
module tplc_remote_term (
	// Code to send: 0 idle ones, 1 loop-up, 2 loop-down
	input wire logic [1:0] code_in,
	// Receive line toward the unit
	output logic [3:0] rx_clk_out,
	output logic [3:0] rx_data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int ph = 0;
	// Line clock is unrelated to clk_in; data moves on its falling edge
	initial begin
		rx_clk_out = 4'h0;
		rx_data_out = 4'hF;
		forever begin
			#130 rx_clk_out = 4'hF;
			#130 rx_clk_out = 4'h0;
			ph = (ph + 1) % 15;
			case (code_in)
				2'h1: rx_data_out = {4{ph % 5 == 4}};
				2'h2: rx_data_out = {4{ph % 3 == 2}};
				default: rx_data_out = 4'hF; // Ones break both codes
			endcase
		end
	end
endmodule // tplc_remote_term
`default_nettype wire

// ---- tplc_unit_monitor.sv ----
// Assertion checker bound to the test pattern and loop code unit
`default_nettype none
// ----------------------------------------------------------------------
// Checker
// ----------------------------------------------------------------------
module tplc_unit_monitor #(
	parameter [31:0] QUAL_CYCLES = 40
) (
	// Clock, reset and register port
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic irq_out,
	// Line side
	input wire logic [3:0] receive_clock_in,
	input wire logic [3:0] receive_data_in,
	input wire logic [3:0] tx_pos_out,
	input wire logic [3:0] tx_neg_out,
	input wire logic [3:0] remote_loop_out,
	input wire logic [3:0] loop_code_detected_flag_out
);
	logic [5:0] ctl0;
	logic [3:0] mask;
	logic [1:0] rxs;
	logic rxb;
	logic [31:0] qcnt;
	// Shadow of channel 0 control and mask; qcnt counts since a 11 pair,
	// seen no later than the unit sees it, so it never undercounts
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ctl0 <= 6'h00;
			mask <= 4'h0;
			rxs <= 2'h0;
			rxb <= 1'b0;
			qcnt <= 32'h0;
		end else begin
			if (wr_in && addr_in == 8'h00) ctl0 <= wdata_in[5:0];
			if (wr_in && addr_in == 8'h18) mask <= wdata_in[3:0];
			rxs <= {rxs[0], receive_clock_in[0]};
			if (rxs == 2'h1) rxb <= receive_data_in[0];
			if (rxs == 2'h1 && rxb && receive_data_in[0]) qcnt <= 32'h0;
			else qcnt <= qcnt + 32'h1;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	sequence s_leave_auto;
		wr_in && addr_in == 8'h00 && wdata_in[4:3] != 2'h3;
	endsequence
	sequence s_flag_change;
		|((loop_code_detected_flag_out ^
			$past(loop_code_detected_flag_out)) & mask);
	endsequence
	a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
		else $error("read data outside its slot");
	a_ami_rails: assert property ((tx_pos_out & tx_neg_out) == 4'h0)
		else $error("both rails high");
	a_irq_edge: assert property (s_flag_change |-> ##1 irq_out)
		else $error("flag change without interrupt");
	a_irq_mask: assert property (
		irq_out |-> (|mask) || (|$past(mask)))
		else $error("interrupt while masked");
	a_loop_flag: assert property (
		(remote_loop_out & ~loop_code_detected_flag_out) == 4'h0)
		else $error("loop-back without flag");
	a_leave_auto: assert property (
		s_leave_auto |-> ##[1:3] !remote_loop_out[0])
		else $error("loop-back kept after leaving auto");
	a_aloop_blocks: assert property (
		$rose(remote_loop_out[0]) |-> !$past(ctl0[5]))
		else $error("loop-back under analog loop");
	a_auto_tps: assert property (
		$rose(remote_loop_out[0]) |->
		$past(ctl0[2:0]) != 3'h6 && $past(ctl0[4:3]) == 2'h3)
		else $error("loop-back outside auto mode");
	a_flag_qual: assert property (
		$rose(loop_code_detected_flag_out[0]) |-> qcnt >= QUAL_CYCLES)
		else $error("flag set before qualification");
endmodule // tplc_unit_monitor
bind tplc_unit tplc_unit_monitor #(.QUAL_CYCLES(QUAL_CYCLES)) i_mon (
	.clk_in(clk_in),
	.reset_in(reset_in),
	.addr_in(addr_in),
	.wdata_in(wdata_in),
	.wr_in(wr_in),
	.rd_in(rd_in),
	.rdata_out(rdata_out),
	.irq_out(irq_out),
	.receive_clock_in(receive_clock_in),
	.receive_data_in(receive_data_in),
	.tx_pos_out(tx_pos_out),
	.tx_neg_out(tx_neg_out),
	.remote_loop_out(remote_loop_out),
	.loop_code_detected_flag_out(loop_code_detected_flag_out)
);
`default_nettype wire

// ---- test_tplc_unit.sv ----
// Self-checking bench for the test pattern and loop code unit
`default_nettype none
// ----------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------
module test_tplc_unit;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int QUAL = 40;
	localparam int LIMIT = 60000;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic host = 1'b1;
	logic auto_pin = 1'b0;
	logic [3:0] ones_pin = 4'h0;
	logic [3:0] loss = 4'h0;
	logic [3:0] tx_clk = 4'h0;
	logic [3:0] tpos = 4'h0;
	logic [3:0] tneg = 4'h0;
	logic [1:0] code = 2'h0;
	wire [31:0] rdata;
	wire irq;
	wire [3:0] rx_clk, rx_data, pos, neg, rloop, flag;
	int num_errors = 0;
	int check_count = 0;
	int cyc = 0;
	tplc_remote_term i_far (
		.code_in(code),
		.rx_clk_out(rx_clk),
		.rx_data_out(rx_data)
	);
	tplc_unit #(.QUAL_CYCLES(QUAL)) i_dut (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.addr_in(addr),
		.wdata_in(wdata),
		.wr_in(wr_en),
		.rd_in(rd_en),
		.rdata_out(rdata),
		.irq_out(irq),
		.host_mode_in(host),
		.auto_all_ones_on_loss_pin_in(auto_pin),
		.all_ones_request_pin_in(ones_pin),
		.receive_signal_loss_in(loss),
		.transmit_clock_in(tx_clk),
		.transmit_positive_data_in(tpos),
		.transmit_negative_data_in(tneg),
		.receive_clock_in(rx_clk),
		.receive_data_in(rx_data),
		.tx_pos_out(pos),
		.tx_neg_out(neg),
		.remote_loop_out(rloop),
		.loop_code_detected_flag_out(flag)
	);
	initial forever #20 clk_in = ~clk_in;
	// Transmit clock of eight cycles keeps mark counts exact; hang guard
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		tx_clk <= {4{cyc[2]}};
		if (cyc == LIMIT) begin
			num_errors++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		if (num_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk_in);
		wr_en <= 1'b0;
	endtask
	task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_in);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_in);
		rd_en <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	// Count rail rises per channel over 120 transmit bits
	task automatic marks(output int n [4]);
		logic [3:0] pp, pn;
		n = '{0, 0, 0, 0};
		repeat (40) @(posedge clk_in);
		pp = pos;
		pn = neg;
		repeat (960) begin
			@(posedge clk_in);
			for (int c = 0; c < 4; c++) begin
				n[c] += int'(pos[c] & !pp[c]);
				n[c] += int'(neg[c] & !pn[c]);
			end
			pp = pos;
			pn = neg;
		end
	endtask
	task automatic wait_st(input logic f, input logic l);
		for (int i = 0; i < 600 && flag[0] !== f; i++) @(posedge clk_in);
		repeat (2) @(posedge clk_in);
		chk({flag[0], rloop[0]}, {f, l});
	endtask
	task automatic t_regs();
		bus_rd(8'h00, 32'h0);
		bus_wr(8'h00, 32'h2D);
		bus_rd(8'h00, 32'h2D);
		bus_rd(8'h20, 32'h0);
		bus_wr(8'h1C, 32'hFF);
		bus_rd(8'h1C, 32'h0);
		bus_wr(8'h00, 32'h0);
	endtask
	task automatic t_tx();
		int n [4];
		logic [2:0] sel [5] = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
		int exp [5] = '{0, -1, 120, 24, 40};
		for (int i = 0; i < 5; i++) begin
			bus_wr(8'h00, {29'h0, sel[i]});
			marks(n);
			if (exp[i] < 0) chk(n[0] != 0, 1);
			else chk(n[0], exp[i]);
		end
		bus_wr(8'h00, 32'h0);
	endtask
	task automatic t_hw();
		int n [4];
		@(posedge clk_in);
		host <= 1'b0;
		ones_pin <= 4'h2;
		auto_pin <= 1'b1;
		loss <= 4'h4;
		tpos <= 4'h6;
		tneg <= 4'h6;
		marks(n);
		chk(n[1], 120);
		chk(n[2], 120);
		chk(n[0] + n[3], 0);
		host <= 1'b1;
		ones_pin <= 4'h0;
		auto_pin <= 1'b0;
		loss <= 4'h0;
		tpos <= 4'h0;
		tneg <= 4'h0;
	endtask
	task automatic t_up();
		bus_wr(8'h18, 32'h1);
		bus_wr(8'h00, 32'h8);
		code <= 2'h1;
		wait_st(1'b1, 1'b0);
		chk(irq, 1);
		bus_rd(8'h14, 32'h1);
		bus_wr(8'h14, 32'h1);
		code <= 2'h0;
		wait_st(1'b0, 1'b0);
		bus_rd(8'h14, 32'h1);
		bus_wr(8'h14, 32'h1);
	endtask
	task automatic t_dn();
		bus_wr(8'h18, 32'h0);
		bus_wr(8'h00, 32'h10);
		code <= 2'h2;
		wait_st(1'b1, 1'b0);
		chk(irq, 0);
		bus_rd(8'h14, 32'h1);
		code <= 2'h0;
		wait_st(1'b0, 1'b0);
		bus_wr(8'h14, 32'hF);
		bus_wr(8'h18, 32'h1);
	endtask
	task automatic t_auto();
		bus_wr(8'h00, 32'h18);
		code <= 2'h1;
		wait_st(1'b1, 1'b1);
		bus_rd(8'h14, 32'h1);
		bus_wr(8'h14, 32'h1);
		code <= 2'h0;
		repeat (200) @(posedge clk_in);
		wait_st(1'b1, 1'b1);
		code <= 2'h2;
		wait_st(1'b0, 1'b0);
		bus_rd(8'h14, 32'h1);
		chk(irq, 1);
		code <= 2'h1;
		wait_st(1'b1, 1'b1);
		bus_wr(8'h00, 32'h0);
		repeat (3) @(posedge clk_in);
		chk(rloop[0], 0);
		code <= 2'h0;
		bus_wr(8'h14, 32'hF);
	endtask
	task automatic t_block();
		bus_wr(8'h00, 32'h38);
		code <= 2'h1;
		repeat (400) @(posedge clk_in);
		chk({flag[0], rloop[0]}, 0);
		bus_wr(8'h00, 32'h1E);
		repeat (400) @(posedge clk_in);
		chk(rloop[0], 0);
		code <= 2'h0;
		bus_wr(8'h00, 32'h0);
	endtask
	initial begin
		repeat (5) @(posedge clk_in);
		reset_in <= 1'b0;
		t_regs();
		t_tx();
		t_hw();
		t_up();
		t_dn();
		t_auto();
		t_block();
		end_of_test();
	end
endmodule // test_tplc_unit
`default_nettype wire
